/* File: logic/dmr_pkg.sv */
// Purpose: Shared constants for the mode register group
// Assumes: Commands arrive as three-beat frames on the command pins
// Notes on behaviour
// - Termination value field: 000 off, 001..110 reference resistor fractions, 111 reserved.
// - Clock override bit one terminates clock inputs regardless of the bond pad when value valid.
// - Chip-select override bit one terminates chip select regardless of the bond pad when value valid.
// - Disable bit zero: command/address terminate only when pad high and value valid.
// - Disable bit one: command/address termination always off.
// - One copy per set point; writes and reads reach the write-selected copy.
// - Operation uses only the operating-selected copy; the other copy is ignored.
// - Terminating rank keeps terminating in every power state, self-refresh included.
// - Run time 0 stops by command; 1..4 stop after 16, 32, 48, 64 clocks.
// - With run time zero the stop-oscillator command stops the timer.
// - Activate count field reads the count; 000 means untested unless unlimited.
// - Unlimited flag one means no activate limit and count field reads zero.
// - Targeted row refresh enable bit resets to zero; writing one enables it.
// - Repair register reports one available-resource bit per bank, bank 0 at bit 0.
// - Start-oscillator command clears the previous oscillator count result.
`default_nettype none
package dmr_pkg;
    localparam logic [5:0] ADDR_TERM_CTRL  = 6'h16;
    localparam logic [5:0] ADDR_OSC_RUN    = 6'h17;
    localparam logic [5:0] ADDR_REFRESH    = 6'h18;
    localparam logic [5:0] ADDR_REPAIR     = 6'h19;
    localparam logic [5:0] ADDR_RSVD_FIRST = 6'h1a;
    localparam logic [5:0] ADDR_RSVD_LAST  = 6'h1f;

    localparam int TERM_VALUE_LSB    = 0;
    localparam int CK_OVERRIDE_BIT   = 3;
    localparam int CS_OVERRIDE_BIT   = 4;
    localparam int CA_DISABLE_BIT    = 5;
    localparam int REFRESH_BANK_LSB  = 4;
    localparam int REFRESH_EN_BIT    = 7;
    localparam int ACT_UNLIMITED_BIT = 3;

    localparam logic [2:0] TERM_OFF      = 3'h0;
    localparam logic [2:0] TERM_RESERVED = 3'h7;
    localparam logic [7:0] TERM_RESET    = 8'h00;
    localparam logic [7:0] OSC_RUN_RESET = 8'h00;
    localparam logic [7:0] OSC_RUN_MAX   = 8'h04;
    localparam logic [7:0] REFRESH_RESET = 8'h00;

    localparam logic [6:0] MPC_OSC_START = 7'h4b;
    localparam logic [6:0] MPC_OSC_STOP  = 7'h4d;

    localparam int OSC_STEP_CLOCKS = 16;

    typedef enum logic [1:0] {
        DMR_CMD_NOP = 2'b00,
        DMR_CMD_MRW = 2'b01,
        DMR_CMD_MRR = 2'b10,
        DMR_CMD_MPC = 2'b11
    } dmr_cmd_e;

    typedef enum logic [1:0] {
        DMR_BEAT_IDLE = 2'b00,
        DMR_BEAT_ADDR = 2'b01,
        DMR_BEAT_DATA = 2'b10
    } dmr_beat_e;
endpackage
`default_nettype wire

/* File: logic/dmr_sync.sv */
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second
`default_nettype none
module dmr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: logic/dmr_osc_timer.sv */
// Purpose: Strobe interval timer run control
// Assumes: ck_tick pulses once per link clock rising edge
// Notes: Counts link clocks, not system clocks
`default_nettype none
module dmr_osc_timer
    import dmr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       ck_tick,
    input  wire logic [7:0] run_time,
    input  wire logic       start_cmd,
    input  wire logic       stop_cmd,
    output logic            osc_active,
    output logic            osc_clear,
    output logic [7:0]      osc_elapsed
);
    logic [7:0] limit;

    // Step encoding: each run time code adds sixteen link clocks
    assign limit = 8'(run_time * OSC_STEP_CLOCKS);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_active  <= 1'b0;
            osc_elapsed <= 8'h00;
        end else if (start_cmd) begin
            osc_active  <= 1'b1;
            osc_elapsed <= 8'h00;
        end else if (osc_active) begin
            if (stop_cmd && run_time == 8'h00) begin
                osc_active <= 1'b0;
            end else if (ck_tick) begin
                osc_elapsed <= osc_elapsed + 8'h01;
                if (run_time != 8'h00 && osc_elapsed + 8'h01 == limit) begin
                    osc_active <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_clear <= 1'b0;
        end else begin
            osc_clear <= start_cmd;
        end
    end
endmodule
`default_nettype wire

/* File: logic/dmr_mode_regs.sv */
// Purpose: Termination, oscillator run time, row refresh and repair mode registers
// Assumes: Link clock well below half the system clock; pins synchronised here
// Notes: Frames are three chip-select-high beats sampled on link clock rising edges
`default_nettype none
module dmr_mode_regs
    import dmr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       link_ck,
    input  wire logic       link_cs,
    input  wire logic [5:0] link_ca,
    input  wire logic       termination_bond_pad,
    input  wire logic       write_set_point_select,
    input  wire logic       operating_set_point_select,
    input  wire logic [2:0] ca_term_value,
    input  wire logic [2:0] max_activate_count,
    input  wire logic       max_activate_unlimited,
    input  wire logic [7:0] post_package_repair,
    output logic [7:0]      mr_read_data,
    output logic            mr_read_valid,
    output logic [2:0]      controller_term_value,
    output logic [1:0]      byte_select_term_disable,
    output logic            clock_term_en,
    output logic            chip_select_term_en,
    output logic            cmd_addr_term_en,
    output logic            targeted_row_refresh_en,
    output logic [2:0]      targeted_row_refresh_bank,
    output logic            osc_active,
    output logic            osc_clear,
    output logic [7:0]      osc_elapsed
);
    logic [7:0] pins_sync;
    logic       ck_s;
    logic       cs_s;
    logic [5:0] ca_s;
    logic       pad_s;
    logic       ck_prev;
    logic       ck_tick;

    dmr_sync #(.WIDTH(8)) u_pin_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({link_ck, link_cs, link_ca}),
        .sync_out (pins_sync)
    );

    dmr_sync #(.WIDTH(1)) u_pad_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (termination_bond_pad),
        .sync_out (pad_s)
    );

    assign ck_s = pins_sync[7];
    assign cs_s = pins_sync[6];
    assign ca_s = pins_sync[5:0];

    // Edge detect on the synchronised copy only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ck_prev <= 1'b0;
        end else begin
            ck_prev <= ck_s;
        end
    end

    assign ck_tick = ck_s & ~ck_prev;

    // Frame capture
    dmr_beat_e  beat;
    dmr_cmd_e   frame_cmd;
    logic [1:0] frame_op_hi;
    logic [5:0] frame_addr;
    logic       frame_done;
    logic [7:0] frame_op;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            beat        <= DMR_BEAT_IDLE;
            frame_cmd   <= DMR_CMD_NOP;
            frame_op_hi <= 2'h0;
            frame_addr  <= 6'h00;
            frame_done  <= 1'b0;
            frame_op    <= 8'h00;
        end else begin
            frame_done <= 1'b0;
            if (ck_tick) begin
                case (beat)
                    DMR_BEAT_IDLE: begin
                        if (cs_s && dmr_cmd_e'(ca_s[5:4]) != DMR_CMD_NOP) begin
                            frame_cmd   <= dmr_cmd_e'(ca_s[5:4]);
                            frame_op_hi <= ca_s[1:0];
                            beat        <= DMR_BEAT_ADDR;
                        end
                    end
                    DMR_BEAT_ADDR: begin
                        // A missing chip select abandons the frame
                        if (cs_s) begin
                            frame_addr <= ca_s;
                            beat       <= DMR_BEAT_DATA;
                        end else begin
                            beat <= DMR_BEAT_IDLE;
                        end
                    end
                    DMR_BEAT_DATA: begin
                        if (cs_s) begin
                            frame_op   <= {frame_op_hi, ca_s};
                            frame_done <= 1'b1;
                        end
                        beat <= DMR_BEAT_IDLE;
                    end
                    default: begin
                        beat <= DMR_BEAT_IDLE;
                    end
                endcase
            end
        end
    end

    logic is_write;
    logic is_read;
    logic is_mpc;
    assign is_write = frame_done && frame_cmd == DMR_CMD_MRW;
    assign is_read  = frame_done && frame_cmd == DMR_CMD_MRR;
    assign is_mpc   = frame_done && frame_cmd == DMR_CMD_MPC;

    // Termination register, one copy per set point
    logic [7:0] term_copy [2];

    generate
        for (genvar sp = 0; sp < 2; sp++) begin : g_set_point
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    term_copy[sp] <= TERM_RESET;
                end else if (is_write && frame_addr == ADDR_TERM_CTRL
                             && write_set_point_select == 1'(sp)) begin
                    term_copy[sp] <= frame_op;
                end
            end
        end
    endgenerate

    logic [7:0] term_op;
    logic       ca_value_valid;
    assign term_op        = term_copy[operating_set_point_select];
    assign ca_value_valid = ca_term_value != TERM_OFF && ca_term_value != TERM_RESERVED;

    // Termination is not gated by any power state, so it holds through self-refresh
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            controller_term_value    <= TERM_OFF;
            byte_select_term_disable <= 2'h0;
            clock_term_en            <= 1'b0;
            chip_select_term_en      <= 1'b0;
            cmd_addr_term_en         <= 1'b0;
        end else begin
            controller_term_value    <= term_op[TERM_VALUE_LSB +: 3];
            byte_select_term_disable <= term_op[7:6];
            clock_term_en            <= ca_value_valid
                                        && (pad_s || term_op[CK_OVERRIDE_BIT]);
            chip_select_term_en      <= ca_value_valid
                                        && (pad_s || term_op[CS_OVERRIDE_BIT]);
            cmd_addr_term_en         <= !term_op[CA_DISABLE_BIT]
                                        && pad_s && ca_value_valid;
        end
    end

    // Oscillator run time
    logic [7:0] osc_run_time;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_run_time <= OSC_RUN_RESET;
        end else if (is_write && frame_addr == ADDR_OSC_RUN) begin
            // Codes above the last step are dropped, keeping the old setting
            if (frame_op <= OSC_RUN_MAX) begin
                osc_run_time <= frame_op;
            end
        end
    end

    logic osc_start;
    logic osc_stop;
    assign osc_start = is_mpc && frame_op[6:0] == MPC_OSC_START;
    assign osc_stop  = is_mpc && frame_op[6:0] == MPC_OSC_STOP;

    dmr_osc_timer u_osc_timer (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .ck_tick     (ck_tick),
        .run_time    (osc_run_time),
        .start_cmd   (osc_start),
        .stop_cmd    (osc_stop),
        .osc_active  (osc_active),
        .osc_clear   (osc_clear),
        .osc_elapsed (osc_elapsed)
    );

    // Targeted row refresh control
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            targeted_row_refresh_en   <= REFRESH_RESET[REFRESH_EN_BIT];
            targeted_row_refresh_bank <= REFRESH_RESET[REFRESH_BANK_LSB +: 3];
        end else if (is_write && frame_addr == ADDR_REFRESH) begin
            targeted_row_refresh_en   <= frame_op[REFRESH_EN_BIT];
            targeted_row_refresh_bank <= frame_op[REFRESH_BANK_LSB +: 3];
        end
    end

    // Read path; addresses outside this group give no answer
    logic [7:0] next_read_data;
    logic       read_hit;

    always_comb begin
        next_read_data = 8'h00;
        read_hit       = 1'b1;
        if (frame_addr == ADDR_TERM_CTRL) begin
            next_read_data = term_copy[write_set_point_select];
        end else if (frame_addr == ADDR_OSC_RUN) begin
            next_read_data = osc_run_time;
        end else if (frame_addr == ADDR_REFRESH) begin
            next_read_data[REFRESH_EN_BIT]         = targeted_row_refresh_en;
            next_read_data[REFRESH_BANK_LSB +: 3]  = targeted_row_refresh_bank;
            next_read_data[ACT_UNLIMITED_BIT]      = max_activate_unlimited;
            next_read_data[2:0]                    = max_activate_unlimited ? 3'h0 : max_activate_count;
        end else if (frame_addr == ADDR_REPAIR) begin
            next_read_data = post_package_repair;
        end else if (frame_addr >= ADDR_RSVD_FIRST && frame_addr <= ADDR_RSVD_LAST) begin
            next_read_data = 8'h00;
        end else begin
            read_hit = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mr_read_data  <= 8'h00;
            mr_read_valid <= 1'b0;
        end else begin
            mr_read_valid <= is_read && read_hit;
            if (is_read && read_hit) begin
                mr_read_data <= next_read_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/dmr_mode_regs_properties.sv */
// Purpose: Port-level checks for the mode register group
// Assumes: Termination inputs are levels of the system clock domain
// Notes: Pad passes a synchroniser, so its checks wait longer
`default_nettype none
module dmr_mode_regs_properties (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       termination_bond_pad,
    input wire logic [2:0] ca_term_value,
    input wire logic [7:0] mr_read_data,
    input wire logic       mr_read_valid,
    input wire logic       clock_term_en,
    input wire logic       chip_select_term_en,
    input wire logic       cmd_addr_term_en,
    input wire logic       osc_active,
    input wire logic       osc_clear,
    input wire logic [7:0] osc_elapsed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_bad_value;
        (ca_term_value == 3'h0 || ca_term_value == 3'h7) [*3];
    endsequence
    property p_ck_off; s_bad_value |-> !clock_term_en; endproperty
    a_ck_off: assert property (p_ck_off) else $error("clock termination on without a valid value");
    property p_cs_off; s_bad_value |-> !chip_select_term_en; endproperty
    a_cs_off: assert property (p_cs_off) else $error("chip select termination on without a valid value");
    property p_ca_value; s_bad_value |-> !cmd_addr_term_en; endproperty
    a_ca_value: assert property (p_ca_value) else $error("command termination on without a valid value");
    // Three flops between pad pin and output, five cycles leaves margin
    property p_ca_pad; (!termination_bond_pad) [*5] |-> !cmd_addr_term_en; endproperty
    a_ca_pad: assert property (p_ca_pad) else $error("command termination on with pad low");
    property p_read_pulse; mr_read_valid |=> !mr_read_valid; endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read valid longer than one cycle");
    property p_read_hold; !mr_read_valid |-> $stable(mr_read_data); endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved without valid");
    property p_clear_start; $rose(osc_active) |-> ##[0:1] osc_clear; endproperty
    a_clear_start: assert property (p_clear_start) else $error("timer start without clear pulse");
    property p_clear_zero; osc_clear |-> ##[0:1] (osc_elapsed == 8'h00); endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("count not cleared on start");
    property p_step;
        osc_active && $past(osc_active) && !osc_clear && !$past(osc_clear) && $changed(osc_elapsed)
            |-> osc_elapsed == 8'($past(osc_elapsed) + 8'h01);
    endproperty
    a_step: assert property (p_step) else $error("timer count skipped");
    c_read: cover property (mr_read_valid);
    c_start: cover property ($rose(osc_active));
    c_ck_term: cover property (clock_term_en && !termination_bond_pad);
endmodule
bind dmr_mode_regs dmr_mode_regs_properties chk_u (.clock, .sys_rst, .termination_bond_pad, .ca_term_value,
    .mr_read_data, .mr_read_valid, .clock_term_en, .chip_select_term_en, .cmd_addr_term_en,
    .osc_active, .osc_clear, .osc_elapsed);
`default_nettype wire

/* File: bench/dmr_ctrl_model.sv */
// Purpose: Controller model sending command frames on the link pins
// Assumes: Pins move on falling system clock edges
// Notes: Link clock idles low between frames; released lines show the inverse
`default_nettype none
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input  wire logic  clock,
    output logic       link_ck,
    output logic       link_cs,
    output logic [5:0] link_ca
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_time = 8'h00;
    initial begin
        link_ck = 1'b0;
        link_cs = 1'b0;
        link_ca = 6'h00;
    end
    task automatic pulse();
        repeat (5) @(negedge clock);
        link_ck = 1'b1;
        repeat (5) @(negedge clock);
        link_ck = 1'b0;
    endtask
    task automatic frame(input logic [1:0] cmd, input logic [5:0] addr, input logic [7:0] op);
        logic [7:0] o;
        o = op;
        if (cmd == DMR_CMD_MRW && addr == ADDR_TERM_CTRL) o[7:6] = 2'b00;
        if (cmd == DMR_CMD_MRW && addr == ADDR_OSC_RUN && o <= OSC_RUN_MAX) run_time = o;
        if (cmd == DMR_CMD_MPC && o[6:0] == MPC_OSC_STOP && run_time != 8'h00) return;
        link_cs = 1'b1;
        link_ca = {cmd, 2'b00, o[7:6]};
        pulse();
        link_ca = addr;
        pulse();
        link_ca = o[5:0];
        pulse();
        link_cs = 1'b0;
        link_ca = ~link_ca;
    endtask
    // Write frame whose last beat drops chip select; the device must discard it
    task automatic cut_frame(input logic [5:0] addr, input logic [7:0] op);
        link_cs = 1'b1;
        link_ca = {DMR_CMD_MRW, 2'b00, op[7:6]};
        pulse();
        link_ca = addr;
        pulse();
        link_cs = 1'b0;
        link_ca = op[5:0];
        pulse();
        link_ca = ~link_ca;
    endtask
    // Deselected clocks keep the strobe timer counting
    task automatic idle(input int n);
        repeat (n) begin
            link_ca = ~link_ca;
            pulse();
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/dmr_mode_regs_test.sv */
// Purpose: Self-checking bench for the mode register group
// Assumes: Level inputs settle within eight clocks
// Notes: Read answers are captured by a monitor, not polled in the task
`default_nettype none
module dmr_mode_regs_test
    import dmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, sys_rst = 1'b1, link_ck, link_cs, termination_bond_pad = 1'b0;
    logic write_set_point_select = 1'b0, operating_set_point_select = 1'b0, max_activate_unlimited = 1'b0;
    logic [5:0] link_ca;
    logic [2:0] ca_term_value = 3'h0, max_activate_count = 3'h0, controller_term_value, targeted_row_refresh_bank;
    logic [7:0] post_package_repair = 8'h00, mr_read_data, osc_elapsed, got_d;
    logic [1:0] byte_select_term_disable;
    logic mr_read_valid, clock_term_en, chip_select_term_en, cmd_addr_term_en, targeted_row_refresh_en;
    logic osc_active, osc_clear, got_v = 1'b0;
    int n_fail = 0, samples_checked = 0, n_clr = 0, cycles = 0, n0;
    always #4 clock = ~clock;
    dmr_ctrl_model ctrl_u (.clock, .link_ck, .link_cs, .link_ca);
    dmr_mode_regs dut_u (.clock, .sys_rst, .link_ck, .link_cs, .link_ca, .termination_bond_pad,
        .write_set_point_select, .operating_set_point_select, .ca_term_value, .max_activate_count,
        .max_activate_unlimited, .post_package_repair, .mr_read_data, .mr_read_valid, .controller_term_value,
        .byte_select_term_disable, .clock_term_en, .chip_select_term_en, .cmd_addr_term_en,
        .targeted_row_refresh_en, .targeted_row_refresh_bank, .osc_active, .osc_clear, .osc_elapsed);
    always @(posedge clock) begin
        if (mr_read_valid === 1'b1) begin
            got_d <= mr_read_data;
            got_v <= 1'b1;
        end
        if (osc_clear === 1'b1) n_clr <= n_clr + 1;
        cycles <= cycles + 1;
        // Whole run is near four thousand cycles
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (8) @(negedge clock);
    endtask
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        ctrl_u.frame(DMR_CMD_MRW, a, d);
        repeat (3) @(negedge clock);
    endtask
    task automatic mrr(input logic [5:0] a, input logic [7:0] exp, input logic ok);
        got_v = 1'b0;
        ctrl_u.frame(DMR_CMD_MRR, a, 8'h00);
        repeat (10) @(negedge clock);
        chk("read valid", ok, got_v);
        if (ok) chk("read data", exp, got_d);
    endtask
    task automatic term(input logic [2:0] e);
        settle();
        chk("clock_term_en", e[2], clock_term_en);
        chk("chip_select_term_en", e[1], chip_select_term_en);
        chk("cmd_addr_term_en", e[0], cmd_addr_term_en);
    endtask
    task automatic osc(input logic [6:0] op);
        n0 = n_clr;
        ctrl_u.frame(DMR_CMD_MPC, 6'h00, {1'b0, op});
        repeat (4) @(negedge clock);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        settle();
        mrr(ADDR_TERM_CTRL, TERM_RESET, 1'b1);
        mrr(ADDR_OSC_RUN, OSC_RUN_RESET, 1'b1);
        mrr(ADDR_REFRESH, REFRESH_RESET, 1'b1);
        $display("test reset done");
        ca_term_value = 3'h2;
        mrw(ADDR_TERM_CTRL, 8'h3b);
        write_set_point_select = 1'b1;
        settle();
        mrw(ADDR_TERM_CTRL, 8'h05);
        mrr(ADDR_TERM_CTRL, 8'h05, 1'b1);
        write_set_point_select = 1'b0;
        settle();
        mrr(ADDR_TERM_CTRL, 8'h3b, 1'b1);
        term(3'b110);
        chk("controller_term_value", 8'h03, controller_term_value);
        chk("byte_select_term_disable", 8'h00, byte_select_term_disable);
        operating_set_point_select = 1'b1;
        term(3'b000);
        chk("controller_term_value", 8'h05, controller_term_value);
        termination_bond_pad = 1'b1;
        term(3'b111);
        ca_term_value = 3'h7;
        term(3'b000);
        ca_term_value = 3'h0;
        term(3'b000);
        $display("test termination done");
        for (int rt = 1; rt <= 4; rt++) begin
            mrw(ADDR_OSC_RUN, 8'(rt));
            mrw(ADDR_OSC_RUN, 8'h05);
            mrr(ADDR_OSC_RUN, 8'(rt), 1'b1);
            osc(MPC_OSC_START);
            chk("osc_clear count", 8'(n0 + 1), 8'(n_clr));
            chk("osc_elapsed start", 8'h00, osc_elapsed);
            ctrl_u.idle(OSC_STEP_CLOCKS * rt - 1);
            repeat (3) @(negedge clock);
            chk("osc_active early", 8'h01, osc_active);
            ctrl_u.idle(1);
            repeat (3) @(negedge clock);
            chk("osc_active end", 8'h00, osc_active);
            chk("osc_elapsed end", 8'(OSC_STEP_CLOCKS * rt), osc_elapsed);
        end
        mrw(ADDR_OSC_RUN, 8'h00);
        osc(MPC_OSC_START);
        ctrl_u.idle(20);
        repeat (3) @(negedge clock);
        chk("osc_active run", 8'h01, osc_active);
        osc(MPC_OSC_STOP);
        chk("osc_active stop", 8'h00, osc_active);
        ctrl_u.cut_frame(ADDR_OSC_RUN, 8'h03);
        repeat (3) @(negedge clock);
        mrr(ADDR_OSC_RUN, 8'h00, 1'b1);
        $display("test timer done");
        max_activate_count = 3'h5;
        settle();
        mrr(ADDR_REFRESH, 8'h05, 1'b1);
        max_activate_unlimited = 1'b1;
        settle();
        mrr(ADDR_REFRESH, 8'h08, 1'b1);
        for (int b = 0; b < 8; b++) begin
            mrw(ADDR_REFRESH, {1'b1, 3'(b), 4'h0});
            chk("targeted_row_refresh_en", 8'h01, targeted_row_refresh_en);
            chk("targeted_row_refresh_bank", 8'(b), targeted_row_refresh_bank);
        end
        mrr(ADDR_REFRESH, 8'hf8, 1'b1);
        mrw(ADDR_REFRESH, 8'h00);
        chk("targeted_row_refresh_en off", 8'h00, targeted_row_refresh_en);
        post_package_repair = 8'ha5;
        settle();
        mrw(ADDR_REPAIR, 8'hff);
        mrr(ADDR_REPAIR, 8'ha5, 1'b1);
        for (logic [5:0] a = ADDR_RSVD_FIRST; a <= ADDR_RSVD_LAST; a++) begin
            mrw(a, 8'hff);
            mrr(a, 8'h00, 1'b1);
            if (a == ADDR_RSVD_LAST) break;
        end
        mrr(6'h20, 8'h00, 1'b0);
        $display("test status and reserved done");
        report_and_stop();
    end
endmodule
`default_nettype wire
